// >>> inc/wecs_pkg.sv
// Constants shared by the wake-up event control and status block.
package wecs_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [11:0] WECS_CTRL_OFF    = 12'h068;
  localparam logic [11:0] WECS_PATTERN_OFF = 12'h070;
  localparam logic [11:0] WECS_MASK_OFF    = 12'h0A0;
  localparam logic [11:0] WECS_LIVE_OFF    = 12'h0A4;

  // ----------------------------------------------------------------
  // Field positions of the wake control and status register
  // ----------------------------------------------------------------
  localparam int WECS_CRC_SEL_BIT    = 30;
  localparam int WECS_PAT_EN_HI      = 29;
  localparam int WECS_PAT_EN_LO      = 25;
  localparam int WECS_LINK_DOWN_BIT  = 17;
  localparam int WECS_LINK_UP_BIT    = 16;
  localparam int WECS_FRAME_EV_BIT   = 10;
  localparam int WECS_REMOTE_EV_BIT  = 9;
  localparam int WECS_LINK_EV_BIT    = 8;
  localparam int WECS_FRAME_FLAG_BIT = 2;
  localparam int WECS_REMOTE_FLAG_BIT = 1;
  localparam int WECS_LINK_FLAG_BIT  = 0;

  // ----------------------------------------------------------------
  // Sizes and reset values
  // ----------------------------------------------------------------
  localparam int          WECS_PATTERNS      = 5;
  localparam int          WECS_PORT_WORDS    = 25;
  localparam logic [15:0] WECS_SEED_ZERO     = 16'h0000;
  localparam logic [15:0] WECS_SEED_ONES     = 16'hFFFF;
  localparam logic [4:0]  WECS_PAT_EN_RST    = 5'h00;
  localparam logic [2:0]  WECS_FLAGS_RST     = 3'h0;
  localparam logic [2:0]  WECS_MASK_RST      = 3'h0;
  localparam logic [31:0] WECS_WORD_RST      = 32'h0000_0000;

endpackage

// >>> inc/wecs_link_if.sv
// Link transition events passed from the link detector to the register block.
`timescale 1ns/100ps
interface wecs_link_if;
  logic went_up;
  logic went_down;
  logic live;
  modport src (output went_up, output went_down, output live);
  modport snk (input went_up, input went_down, input live);
endinterface

// >>> rtl/wecs_link_detect.sv
// Detects up and down transitions of the link status level.
`timescale 1ns/100ps
module wecs_link_detect
(
  // Clock and reset
  input  wire logic  ref_clk,
  input  wire logic  rst,
  // Link status level
  input  wire logic  link_status,
  // Transition events
  wecs_link_if.src   evt
);

  logic prev_r;
  logic primed_r;
  logic up_r;
  logic down_r;

  // The first sample after reset only primes the history, so a link that is
  // already up at release is not reported as a transition.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      prev_r   <= 1'b0;
      primed_r <= 1'b0;
      up_r     <= 1'b0;
      down_r   <= 1'b0;
    end
    else
    begin
      prev_r   <= link_status;
      primed_r <= 1'b1;
      up_r     <= primed_r & link_status & ~prev_r;
      down_r   <= primed_r & ~link_status & prev_r;
    end
  end

  assign evt.went_up   = up_r;
  assign evt.went_down = down_r;
  assign evt.live      = prev_r;

endmodule // wecs_link_detect

// >>> rtl/wecs_pattern_store.sv
// Holds the 25 words of wake-up pattern data loaded through the data port.
`timescale 1ns/100ps
module wecs_pattern_store
  import wecs_pkg::*;
(
  // Clock and reset
  input  wire logic                       ref_clk,
  input  wire logic                       rst,
  // Load port
  input  wire logic                       restart,
  input  wire logic                       wr_en,
  input  wire logic [31:0]                wr_data,
  // Stored table and load position
  output logic      [WECS_PORT_WORDS-1:0][31:0] table_words,
  output logic      [4:0]                 load_index
);

  localparam logic [4:0] LAST_INDEX = 5'(WECS_PORT_WORDS - 1);

  logic [WECS_PORT_WORDS-1:0][31:0] words_r;
  logic [4:0]                       index_r;
  logic [4:0]                       index_nxt;

  // Writes fill the table in order and wrap, so a full load of all five
  // patterns always begins again at the first mask word.
  assign index_nxt = (index_r == LAST_INDEX) ? 5'h00 : index_r + 5'h01;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      index_r <= 5'h00;
    end
    else if (restart)
    begin
      index_r <= 5'h00;
    end
    else if (wr_en)
    begin
      index_r <= index_nxt;
    end
  end

  genvar g;
  generate
    for (g = 0; g < WECS_PORT_WORDS; g++)
    begin : g_word
      always_ff @(posedge ref_clk or posedge rst)
      begin
        if (rst)
        begin
          words_r[g] <= WECS_WORD_RST;
        end
        else if (wr_en && index_r == 5'(g))
        begin
          words_r[g] <= wr_data;
        end
      end
    end
  endgenerate

  assign table_words = words_r;
  assign load_index  = index_r;

endmodule // wecs_pattern_store

// >>> rtl/wecs_top.sv
// Wake-up event control and status register block with APB access.
//
// Functional notes
// - Seed select bit chooses zero or ones seed.
// - Five per-pattern match enables, reset to zero.
// - Link-down enable lets down transition set flag.
// - Link-up enable lets up transition set flag.
// - Frame event enable raises power event status.
// - Remote packet enable raises event; strap default.
// - Link change enable raises power event status.
// - Wake frame receipt sets its sticky flag.
// - Remote packet receipt sets its sticky flag.
// - Link change detection sets its sticky flag.
// - Flags clear by write-one or power-up only.
// - Five patterns load as 25 port words.
`timescale 1ns/100ps
module wecs_top
  import wecs_pkg::*;
(
  // Clock and power-up reset
  input  wire logic                        ref_clk,
  input  wire logic                        rst,
  // Hardware or software reset, synchronous, leaves the flags alone
  input  wire logic                        soft_rst,
  // Configuration straps for the remote wake default
  input  wire logic                        cfg_pm_enable,
  input  wire logic                        cfg_lan_wake_feature,
  // APB slave
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [11:0]                 paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  // Receive-side events
  input  wire logic                        link_status,
  input  wire logic [WECS_PATTERNS-1:0]    pattern_match,
  input  wire logic                        remote_wake_packet,
  // Results
  output logic      [15:0]                 crc_seed,
  output logic      [WECS_PATTERNS-1:0]    pattern_match_enable,
  output logic      [WECS_PORT_WORDS-1:0][31:0] pattern_table,
  output logic                             pm_event_status,
  output logic                             irq
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [11:0] addr, input logic [11:0] off);
    hit = (addr[11:2] == off[11:2]);
  endfunction

  logic access;
  logic wr_strobe;
  logic hit_ctrl;
  logic hit_pattern;
  logic hit_mask;
  logic hit_live;
  logic mapped;
  logic pready_r;

  assign access      = psel & penable;
  assign wr_strobe   = access & pready_r & pwrite;
  assign hit_ctrl    = hit(paddr, WECS_CTRL_OFF);
  assign hit_pattern = hit(paddr, WECS_PATTERN_OFF);
  assign hit_mask    = hit(paddr, WECS_MASK_OFF);
  assign hit_live    = hit(paddr, WECS_LIVE_OFF);
  assign mapped      = hit_ctrl | hit_pattern | hit_mask | hit_live;

  logic wr_ctrl;
  logic wr_pattern;
  logic wr_mask;

  assign wr_ctrl    = wr_strobe & hit_ctrl;
  assign wr_pattern = wr_strobe & hit_pattern;
  assign wr_mask    = wr_strobe & hit_mask;

  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  logic                     crc_sel_r;
  logic [WECS_PATTERNS-1:0] pat_en_r;
  logic                     link_down_detect_enable_r;
  logic                     link_up_detect_enable_r;
  logic                     wake_frame_event_enable_r;
  logic                     remote_wake_packet_event_enable_r;
  logic                     link_change_event_enable_r;
  logic                     strap_load_r;

  // The remote wake default depends on straps, which are caught by a
  // clocked load in the cycle after reset release, never by the reset.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      strap_load_r <= 1'b1;
    end
    else
    begin
      strap_load_r <= soft_rst;
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      crc_sel_r                  <= 1'b0;
      pat_en_r                   <= WECS_PAT_EN_RST;
      link_down_detect_enable_r  <= 1'b0;
      link_up_detect_enable_r    <= 1'b0;
      wake_frame_event_enable_r  <= 1'b0;
      link_change_event_enable_r <= 1'b0;
    end
    else if (soft_rst)
    begin
      crc_sel_r                  <= 1'b0;
      pat_en_r                   <= WECS_PAT_EN_RST;
      link_down_detect_enable_r  <= 1'b0;
      link_up_detect_enable_r    <= 1'b0;
      wake_frame_event_enable_r  <= 1'b0;
      link_change_event_enable_r <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      crc_sel_r                  <= pwdata[WECS_CRC_SEL_BIT];
      pat_en_r                   <= pwdata[WECS_PAT_EN_HI:WECS_PAT_EN_LO];
      link_down_detect_enable_r  <= pwdata[WECS_LINK_DOWN_BIT];
      link_up_detect_enable_r    <= pwdata[WECS_LINK_UP_BIT];
      wake_frame_event_enable_r  <= pwdata[WECS_FRAME_EV_BIT];
      link_change_event_enable_r <= pwdata[WECS_LINK_EV_BIT];
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      remote_wake_packet_event_enable_r <= 1'b0;
    end
    else if (strap_load_r)
    begin
      remote_wake_packet_event_enable_r <= cfg_pm_enable & cfg_lan_wake_feature;
    end
    else if (wr_ctrl)
    begin
      remote_wake_packet_event_enable_r <= pwdata[WECS_REMOTE_EV_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Link transitions
  // ----------------------------------------------------------------
  wecs_link_if link_evt ();

  wecs_link_detect u_link
  (
    .ref_clk     (ref_clk),
    .rst         (rst),
    .link_status (link_status),
    .evt         (link_evt)
  );

  // ----------------------------------------------------------------
  // Event qualification
  // ----------------------------------------------------------------
  logic frame_evt;
  logic link_chg_evt;
  logic pm_evt;
  logic [WECS_PATTERNS-1:0] pat_en_by_match;

  // The enable field has pattern one on top, the match inputs at bit zero.
  assign pat_en_by_match = {<<{pat_en_r}};
  assign frame_evt    = |(pattern_match & pat_en_by_match);
  assign link_chg_evt = (link_evt.went_down & link_down_detect_enable_r)
                      | (link_evt.went_up & link_up_detect_enable_r);
  assign pm_evt       = (frame_evt & wake_frame_event_enable_r)
                      | (remote_wake_packet & remote_wake_packet_event_enable_r)
                      | (link_chg_evt & link_change_event_enable_r);

  // ----------------------------------------------------------------
  // Sticky flags
  // ----------------------------------------------------------------
  logic [2:0] flags_r;
  logic [2:0] flags_nxt;
  logic [2:0] flag_set;
  logic [2:0] flag_clr;

  assign flag_set[WECS_FRAME_FLAG_BIT]  = frame_evt;
  assign flag_set[WECS_REMOTE_FLAG_BIT] = remote_wake_packet;
  assign flag_set[WECS_LINK_FLAG_BIT]   = link_chg_evt;
  assign flag_clr  = wr_ctrl ? pwdata[2:0] : 3'h0;
  // A new event in the clearing cycle survives the clear.
  assign flags_nxt = (flags_r & ~flag_clr) | flag_set;

  // Only the power-up reset reaches these flops; soft_rst does not.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      flags_r <= WECS_FLAGS_RST;
    end
    else
    begin
      flags_r <= flags_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt mask and outputs
  // ----------------------------------------------------------------
  logic [2:0] mask_r;
  logic       irq_r;
  logic       pm_r;
  logic [2:0] flags_unmasked;

  assign flags_unmasked = flags_nxt & mask_r;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      mask_r <= WECS_MASK_RST;
    end
    else if (soft_rst)
    begin
      mask_r <= WECS_MASK_RST;
    end
    else if (wr_mask)
    begin
      mask_r <= pwdata[2:0];
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      irq_r <= 1'b0;
      pm_r  <= 1'b0;
    end
    else
    begin
      irq_r <= |flags_unmasked;
      pm_r  <= pm_evt;
    end
  end

  // ----------------------------------------------------------------
  // Pattern data port
  // ----------------------------------------------------------------
  logic [4:0] load_index;

  wecs_pattern_store u_store
  (
    .ref_clk     (ref_clk),
    .rst         (rst),
    .restart     (soft_rst),
    .wr_en       (wr_pattern),
    .wr_data     (pwdata),
    .table_words (pattern_table),
    .load_index  (load_index)
  );

  // ----------------------------------------------------------------
  // Read data and handshake
  // ----------------------------------------------------------------
  logic [31:0] ctrl_word;
  logic [31:0] rd_word;
  logic [31:0] prdata_r;
  logic        pslverr_r;
  logic [15:0] crc_seed_r;

  always_comb
  begin
    ctrl_word                          = 32'h0000_0000;
    ctrl_word[WECS_CRC_SEL_BIT]        = crc_sel_r;
    ctrl_word[WECS_PAT_EN_HI:WECS_PAT_EN_LO] = pat_en_r;
    ctrl_word[WECS_LINK_DOWN_BIT]      = link_down_detect_enable_r;
    ctrl_word[WECS_LINK_UP_BIT]        = link_up_detect_enable_r;
    ctrl_word[WECS_FRAME_EV_BIT]       = wake_frame_event_enable_r;
    ctrl_word[WECS_REMOTE_EV_BIT]      = remote_wake_packet_event_enable_r;
    ctrl_word[WECS_LINK_EV_BIT]        = link_change_event_enable_r;
    ctrl_word[2:0]                     = flags_r;
  end

  assign rd_word = hit_ctrl    ? ctrl_word
                 : hit_mask    ? {29'h0, mask_r}
                 : hit_live    ? {26'h0, link_evt.live, load_index}
                 : 32'h0000_0000;

  // One wait state so that read data leaves a flop; writes land on the
  // edge where pready is seen high.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      pready_r  <= 1'b0;
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end
    else
    begin
      pready_r  <= access & ~pready_r;
      prdata_r  <= (access & ~pready_r & ~pwrite) ? rd_word : 32'h0000_0000;
      pslverr_r <= access & ~pready_r & ~mapped;
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      crc_seed_r <= WECS_SEED_ZERO;
    end
    else
    begin
      crc_seed_r <= crc_sel_r ? WECS_SEED_ONES : WECS_SEED_ZERO;
    end
  end

  assign prdata               = prdata_r;
  assign pready               = pready_r;
  assign pslverr              = pslverr_r;
  assign crc_seed             = crc_seed_r;
  assign pattern_match_enable = pat_en_r;
  assign pm_event_status      = pm_r;
  assign irq                  = irq_r;

endmodule // wecs_top

// >>> tb/wecs_checker.sv
// Port-level assertions for the wake-up event control and status block.
`timescale 1ns/100ps
module wecs_checker
  import wecs_pkg::*;
(
  // Clock and resets
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        soft_rst,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Events and results
  input wire logic        link_status,
  input wire logic [4:0]  pattern_match,
  input wire logic        remote_wake_packet,
  input wire logic [15:0] crc_seed,
  input wire logic [4:0]  pattern_match_enable,
  input wire logic        pm_event_status,
  input wire logic        irq
);
  // Shadow of the enables seen by the event paths: {down, up, frame, link}.
  logic [3:0] en_r;
  logic [2:0] mask_r;
  wire logic       ctrl_wr = pready && pwrite && paddr == WECS_CTRL_OFF;
  wire logic       mask_wr = pready && pwrite && paddr == WECS_MASK_OFF;
  wire logic [4:0] en_rev  = {<<{pattern_match_enable}};
  wire logic       mapped  = paddr inside {WECS_CTRL_OFF, WECS_PATTERN_OFF,
                                           WECS_MASK_OFF, WECS_LIVE_OFF};

  always_ff @(posedge ref_clk or posedge rst)
    if (rst || soft_rst)
    begin
      en_r   <= 4'h0;
      mask_r <= 3'h0;
    end
    else
    begin
      if (ctrl_wr)
        en_r <= {pwdata[17], pwdata[16], pwdata[10], pwdata[8]};
      if (mask_wr)
        mask_r <= pwdata[2:0];
    end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence

  AST_WAIT_STATE: assert property (s_setup ##1 s_access |-> !pready ##1 pready)
    else $error("pready not in second access cycle");
  AST_PREADY_PULSE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_REFUSE: assert property (pready && !mapped |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  AST_SEED: assert property (ctrl_wr |=> ##1 crc_seed ==
    ($past(pwdata[30], 2) ? WECS_SEED_ONES : WECS_SEED_ZERO))
    else $error("seed does not follow select bit");
  AST_PAT_EN: assert property (ctrl_wr |=> ##1
    pattern_match_enable == $past(pwdata[29:25], 2))
    else $error("pattern enables wrong");
  AST_FRAME_EV: assert property (en_r[1] && |(pattern_match & en_rev)
    |=> pm_event_status)
    else $error("frame event missing");
  AST_LINK_EV: assert property (en_r[0] && (($rose(link_status) && en_r[2])
    || ($fell(link_status) && en_r[3])) |-> ##[1:3] pm_event_status)
    else $error("link event missing");
  AST_REMOTE_IRQ: assert property (remote_wake_packet && mask_r[1] |=> irq)
    else $error("remote packet did not raise irq");
  AST_IRQ_MASK: assert property (mask_r == 3'h0 && $past(mask_r) == 3'h0 |-> !irq)
    else $error("irq with all sources masked");
endmodule // wecs_checker

bind wecs_top wecs_checker u_chk (.ref_clk, .rst, .soft_rst, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .link_status, .pattern_match,
  .remote_wake_packet, .crc_seed, .pattern_match_enable, .pm_event_status, .irq);

// >>> tb/wecs_top_test.sv
// Self-checking bench for the wake-up event control and status block.
`timescale 1ns/100ps
module wecs_top_test
  import wecs_pkg::*;
;
  logic ref_clk = 0, rst = 1, soft_rst = 0, cfg_pm_enable = 1, cfg_lan_wake_feature = 1;
  logic psel = 0, penable = 0, pwrite = 0, link_status = 0, remote_wake_packet = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd, d, seed = 32'h50A4F630;
  logic [4:0]  pattern_match = 0, pattern_match_enable;
  logic [15:0] crc_seed;
  logic        pready, pslverr, pm_event_status, irq, err, pm;
  logic [WECS_PORT_WORDS-1:0][31:0] pattern_table, words;
  int          fail_count = 0, checked = 0;

  wecs_top u_dut (.ref_clk, .rst, .soft_rst, .cfg_pm_enable, .cfg_lan_wake_feature,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .link_status,
    .pattern_match, .remote_wake_packet, .crc_seed, .pattern_match_enable, .pattern_table,
    .pm_event_status, .irq);

  always #25 ref_clk = ~ref_clk;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Readback of the control word: writable fields plus sticky flags.
  function automatic logic [31:0] ctl(input logic [31:0] v, input logic [2:0] f);
    return (v & 32'h7E03_0700) | {29'h0, f};
  endfunction

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e)
    begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // The request is held until pready is seen high at a rising edge.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge ref_clk);
    penable <= 1;
    // Only the watchdog ends a wait for pready.
    do
      @(posedge ref_clk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic pulse(input logic [4:0] m, input logic r);
    @(posedge ref_clk);
    pattern_match <= m;
    remote_wake_packet <= r;
    @(posedge ref_clk);
    pattern_match <= 0;
    remote_wake_packet <= 0;
    // The power event pulse stands for one cycle only, right after the event edge.
    @(posedge ref_clk);
    pm = pm_event_status;
    @(posedge ref_clk);
  endtask
  task automatic linkt(input logic v);
    @(posedge ref_clk);
    link_status <= v;
    pm = 0;
    repeat (5) @(posedge ref_clk) pm = pm | pm_event_status;
  endtask
  task automatic finish_test();
    $display("Mismatches %0d, checks %0d", fail_count, checked);
    if (fail_count == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    #2000000;
    fail_count++;
    finish_test();
  end

  initial
  begin
    repeat (5) @(posedge ref_clk);
    rst <= 0;
    apb(0, WECS_CTRL_OFF, 0);
    chk(rd, 32'h0000_0200);
    chk(crc_seed, 32'h0);
    for (int i = 0; i < 8; i++)
    begin
      d = (i == 0) ? 32'hFFFF_FFF8 : rnd() & 32'hFFFF_FFF8;
      apb(1, WECS_CTRL_OFF, d);
      apb(0, WECS_CTRL_OFF, 0);
      chk(rd, ctl(d, 0));
      chk(crc_seed, d[30] ? 32'hFFFF : 32'h0);
      chk(pattern_match_enable, d[29:25]);
    end
    apb(1, 12'h0FC, 32'hFFFF_FFFF);
    chk(err, 1);
    apb(0, 12'h0FC, 0);
    chk(err, 1);
    chk(rd, 0);
    // Only pattern one may count; the other four are disabled.
    apb(1, WECS_MASK_OFF, 7);
    apb(1, WECS_CTRL_OFF, 32'h2000_0400);
    pulse(5'h1E, 0);
    chk({pm, irq}, 0);
    pulse(5'h01, 0);
    chk({pm, irq}, 3);
    pulse(0, 1);
    chk(pm, 0);
    apb(0, WECS_CTRL_OFF, 0);
    chk(rd, ctl(32'h2000_0400, 3'h6));
    apb(1, WECS_CTRL_OFF, 32'h0000_0207);
    apb(0, WECS_CTRL_OFF, 0);
    chk(rd, ctl(32'h200, 0));
    pulse(0, 1);
    chk(pm, 1);
    // A soft reset keeps the flags but reloads the strap default.
    @(posedge ref_clk);
    soft_rst <= 1;
    cfg_lan_wake_feature <= 0;
    @(posedge ref_clk);
    soft_rst <= 0;
    apb(0, WECS_CTRL_OFF, 0);
    chk(rd, 32'h2);
    chk(irq, 0);
    apb(1, WECS_CTRL_OFF, 32'h0001_0102);
    linkt(1);
    chk(pm, 1);
    apb(0, WECS_CTRL_OFF, 0);
    chk(rd, ctl(32'h0001_0100, 1));
    apb(1, WECS_CTRL_OFF, 32'h0002_0101);
    linkt(0);
    chk(pm, 1);
    apb(1, WECS_CTRL_OFF, 32'h0002_0101);
    linkt(1);
    chk(pm, 0);
    apb(0, WECS_CTRL_OFF, 0);
    chk(rd, ctl(32'h0002_0100, 0));
    for (int i = 0; i < WECS_PORT_WORDS; i++)
    begin
      words[i] = rnd();
      apb(1, WECS_PATTERN_OFF, words[i]);
    end
    // The last write lands on the edge at which the task returns.
    @(posedge ref_clk);
    for (int i = 0; i < WECS_PORT_WORDS; i++)
      chk(pattern_table[i], words[i]);
    apb(0, WECS_LIVE_OFF, 0);
    chk(rd, 32'h20);
    d = rnd();
    apb(1, WECS_PATTERN_OFF, d);
    @(posedge ref_clk);
    chk(pattern_table[0], d);
    finish_test();
  end
endmodule // wecs_top_test
